// file: rtl/slm_regs.sv
`timescale 1ns/100ps
`default_nettype none

module slm_regs
  import slm_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  // wishbone slave
  input  wire logic                 wb_cyc_in,
  input  wire logic                 wb_stb_in,
  input  wire logic                 wb_we_in,
  input  wire logic [3:0]           wb_sel_in,
  input  wire logic [SLM_ADR_W-1:0] wb_adr_in,
  input  wire logic [SLM_DAT_W-1:0] wb_dat_in,
  output logic      [SLM_DAT_W-1:0] wb_dat_out,
  output logic                      wb_ack_out,
  // detector side, same clock domain
  input  wire logic [1:0]           detector_mode_in,
  input  wire logic                 detector_sample_tick_in,
  // analog and fuse side, asynchronous
  input  wire logic                 comparator_below_in,
  input  wire logic [2:0]           brownout_config_fuse_in,
  // to the analog monitor
  output logic      [2:0]           brownout_threshold_sel_out,
  output logic      [1:0]           monitor_margin_sel_out,
  output logic                      monitor_active_out,
  // interrupt
  output logic                      irq_out
);

  import slm_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [SLM_ADR_W-1:0] adr,
                               input logic [3:0]           idx);
    hit = (adr[SLM_ADR_W-1:2] == idx);
  endfunction

  function automatic logic edge_match(input logic [1:0] sel,
                                      input logic       fall,
                                      input logic       rise);
    unique case (sel)
      SLM_EDGE_FALLING: edge_match = fall;
      SLM_EDGE_RISING:  edge_match = rise;
      SLM_EDGE_BOTH:    edge_match = fall | rise;
      default:          edge_match = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // bus request
  // ****************************************************************
  slm_wb_req_s req;
  logic        bus_go;
  logic        wr_lane0;

  assign req.cyc  = wb_cyc_in;
  assign req.stb  = wb_stb_in;
  assign req.we   = wb_we_in;
  assign req.sel  = wb_sel_in;
  assign req.adr  = wb_adr_in;
  assign req.dat  = wb_dat_in;
  assign bus_go   = req.cyc & req.stb & ~wb_ack_out;
  assign wr_lane0 = bus_go & req.we & req.sel[0];

  // ****************************************************************
  // synchronised inputs
  // ****************************************************************
  logic [3:0] async_bus;
  logic [3:0] sync_bus;
  logic       below_sync;
  logic [2:0] fuse_sync;

  assign async_bus  = {brownout_config_fuse_in, comparator_below_in};
  assign below_sync = sync_bus[0];
  assign fuse_sync  = sync_bus[3:1];

  slm_sync #(
    .WIDTH    (4)
  ) u_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  // ****************************************************************
  // threshold selector, caught from the fuse after reset
  // ****************************************************************
  logic [2:0] thr_r;
  logic [1:0] fuse_wait_r;
  logic       fuse_loaded_r;

  // fuse is sampled once the synchroniser has filled after release
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      fuse_wait_r   <= 2'h0;
      fuse_loaded_r <= 1'b0;
      thr_r         <= SLM_THR_RST;
    end else if (!fuse_loaded_r) begin
      fuse_wait_r <= fuse_wait_r + 2'h1;
      if (fuse_wait_r == 2'(SLM_SYNC_STAGES)) begin
        thr_r         <= fuse_sync;
        fuse_loaded_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  slm_cfg_s cfg_r;
  logic     en_write_rise;

  assign en_write_rise = wr_lane0 & hit(req.adr, SLM_IDX_IRQ_CTRL) &
                         req.dat[SLM_IE_BIT] & ~cfg_r.irq_en;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cfg_r.margin   <= SLM_MARGIN_RST;
      cfg_r.edge_sel <= SLM_EDGE_RST;
      cfg_r.irq_en   <= SLM_IE_RST;
    end else if (wr_lane0) begin
      if (hit(req.adr, SLM_IDX_MARGIN_CTRL)) begin
        cfg_r.margin <= req.dat[SLM_MARGIN_MSB:SLM_MARGIN_LSB];
      end
      if (hit(req.adr, SLM_IDX_IRQ_CTRL)) begin
        cfg_r.edge_sel <= req.dat[SLM_EDGE_MSB:SLM_EDGE_LSB];
        cfg_r.irq_en   <= req.dat[SLM_IE_BIT];
      end
    end
  end

  // ****************************************************************
  // monitor activity and sampling
  // ****************************************************************
  logic det_on;
  logic mon_on;
  logic take;

  assign det_on = (detector_mode_in != SLM_DET_DISABLED);
  // off margin or off detector both silence the monitor
  assign mon_on = det_on & (cfg_r.margin != SLM_MARGIN_OFF);
  // sampled detector mode only looks at the comparator on a tick
  assign take   = mon_on & ((detector_mode_in != SLM_DET_SAMPLED) |
                            detector_sample_tick_in);

  // ****************************************************************
  // level status and crossing detection
  // ****************************************************************
  logic below_r;
  logic seen_r;
  logic fall_ev;
  logic rise_ev;

  // first sample after the monitor wakes only sets the reference
  assign fall_ev = take & seen_r & below_sync & ~below_r;
  assign rise_ev = take & seen_r & ~below_sync & below_r;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      below_r <= SLM_BELOW_RST;
      seen_r  <= 1'b0;
    end else begin
      if (!mon_on) begin
        seen_r <= 1'b0;
      end else if (take) begin
        below_r <= below_sync;
        seen_r  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // interrupt flag
  // ****************************************************************
  logic flag_r;
  logic flag_set;
  logic flag_clr;

  assign flag_set = det_on & (
                    edge_match(cfg_r.edge_sel, fall_ev, rise_ev) |
                    (en_write_rise & mon_on &
                     (req.dat[SLM_EDGE_MSB:SLM_EDGE_LSB] ==
                      SLM_EDGE_BOTH)));
  assign flag_clr = wr_lane0 & hit(req.adr, SLM_IDX_IRQ_FLAGS) &
                    req.dat[SLM_FLAG_BIT];

  // a set in the clearing cycle wins
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      flag_r <= SLM_FLAG_RST;
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= flag_r & cfg_r.irq_en;
    end
  end

  // ****************************************************************
  // analog side outputs
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      brownout_threshold_sel_out <= SLM_THR_RST;
      monitor_margin_sel_out     <= SLM_MARGIN_RST;
      monitor_active_out         <= 1'b0;
    end else begin
      brownout_threshold_sel_out <= thr_r;
      monitor_margin_sel_out     <= cfg_r.margin;
      monitor_active_out         <= mon_on;
    end
  end

  // ****************************************************************
  // read mux and acknowledge
  // ****************************************************************
  logic [SLM_REG_W-1:0] rd_byte;

  // status is only meaningful while the detector runs; software filters
  always_comb begin
    rd_byte = '0;
    if (hit(req.adr, SLM_IDX_THRESHOLD)) begin
      rd_byte[SLM_THR_MSB:SLM_THR_LSB] = thr_r;
    end else if (hit(req.adr, SLM_IDX_MARGIN_CTRL)) begin
      rd_byte[SLM_MARGIN_MSB:SLM_MARGIN_LSB] = cfg_r.margin;
    end else if (hit(req.adr, SLM_IDX_IRQ_CTRL)) begin
      rd_byte[SLM_EDGE_MSB:SLM_EDGE_LSB] = cfg_r.edge_sel;
      rd_byte[SLM_IE_BIT]                = cfg_r.irq_en;
    end else if (hit(req.adr, SLM_IDX_IRQ_FLAGS)) begin
      rd_byte[SLM_FLAG_BIT] = flag_r;
    end else if (hit(req.adr, SLM_IDX_LEVEL_STAT)) begin
      rd_byte[SLM_BELOW_BIT] = below_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_go;
      if (bus_go && !req.we) begin
        wb_dat_out <= {{(SLM_DAT_W-SLM_REG_W){1'b0}}, rd_byte};
      end
    end
  end

endmodule
`default_nettype wire

// file: pkg/slm_pkg.sv
package slm_pkg;

  // ****************************************************************
  // register map: indices; byte address is four times the index
  // ****************************************************************
  localparam logic [3:0] SLM_IDX_THRESHOLD   = 4'h1;
  localparam logic [3:0] SLM_IDX_MARGIN_CTRL = 4'h8;
  localparam logic [3:0] SLM_IDX_IRQ_CTRL    = 4'h9;
  localparam logic [3:0] SLM_IDX_IRQ_FLAGS   = 4'ha;
  localparam logic [3:0] SLM_IDX_LEVEL_STAT  = 4'hb;

  localparam int         SLM_ADR_W   = 6;
  localparam int         SLM_DAT_W   = 32;
  localparam int         SLM_REG_W   = 8;

  // ****************************************************************
  // field layouts
  // ****************************************************************
  localparam int SLM_THR_LSB    = 0;
  localparam int SLM_THR_MSB    = 2;
  localparam int SLM_MARGIN_LSB = 0;
  localparam int SLM_MARGIN_MSB = 1;
  localparam int SLM_IE_BIT     = 0;
  localparam int SLM_EDGE_LSB   = 1;
  localparam int SLM_EDGE_MSB   = 2;
  localparam int SLM_FLAG_BIT   = 0;
  localparam int SLM_BELOW_BIT  = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [1:0] SLM_MARGIN_RST = 2'h0;
  localparam logic [1:0] SLM_EDGE_RST   = 2'h0;
  localparam logic       SLM_IE_RST     = 1'b0;
  localparam logic       SLM_FLAG_RST   = 1'b0;
  localparam logic       SLM_BELOW_RST  = 1'b0;
  localparam logic [2:0] SLM_THR_RST    = 3'h0;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [2:0] SLM_THR_MAX_LEGAL       = 3'h3;
  localparam logic [1:0] SLM_MARGIN_OFF          = 2'h0;
  localparam logic [1:0] SLM_MARGIN_FIVE_PCT     = 2'h1;
  localparam logic [1:0] SLM_MARGIN_FIFTEEN_PCT  = 2'h2;
  localparam logic [1:0] SLM_MARGIN_TWENTYFIVE   = 2'h3;
  localparam logic [1:0] SLM_EDGE_FALLING        = 2'h0;
  localparam logic [1:0] SLM_EDGE_RISING         = 2'h1;
  localparam logic [1:0] SLM_EDGE_BOTH           = 2'h2;
  localparam logic [1:0] SLM_DET_DISABLED        = 2'h0;
  localparam logic [1:0] SLM_DET_CONTINUOUS      = 2'h1;
  localparam logic [1:0] SLM_DET_SAMPLED         = 2'h2;
  localparam logic [1:0] SLM_DET_CONT_WAKE       = 2'h3;
  localparam int         SLM_SYNC_STAGES         = 2;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [3:0]           sel;
    logic [SLM_ADR_W-1:0] adr;
    logic [SLM_DAT_W-1:0] dat;
  } slm_wb_req_s;

  typedef struct packed {
    logic [1:0] margin;
    logic [1:0] edge_sel;
    logic       irq_en;
  } slm_cfg_s;

endpackage

// file: rtl/slm_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// two-stage synchroniser for levels from outside the clock domain
// ****************************************************************
module slm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  // level
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: tb/slm_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module slm_regs_monitor
  import slm_pkg::*;
(
  // clock and reset
  input wire logic                 mclk_in,
  input wire logic                 reset_in,
  // bus
  input wire logic                 wb_cyc_in,
  input wire logic                 wb_stb_in,
  input wire logic                 wb_we_in,
  input wire logic [3:0]           wb_sel_in,
  input wire logic [SLM_ADR_W-1:0] wb_adr_in,
  input wire logic [SLM_DAT_W-1:0] wb_dat_in,
  input wire logic [SLM_DAT_W-1:0] wb_dat_out,
  input wire logic                 wb_ack_out,
  // monitor
  input wire logic [1:0]           detector_mode_in,
  input wire logic [2:0]           brownout_config_fuse_in,
  input wire logic [2:0]           brownout_threshold_sel_out,
  input wire logic [1:0]           monitor_margin_sel_out,
  input wire logic                 monitor_active_out,
  input wire logic                 irq_out
);
  logic [3:0] up_r;
  logic       take;
  logic       wr_m;
  assign take = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_m = take & wb_we_in & wb_sel_in[0]
              & (wb_adr_in[5:2] == SLM_IDX_MARGIN_CTRL);
  // threshold load needs a few edges after release
  always_ff @(posedge mclk_in) begin
    if (reset_in) up_r <= 4'h0;
    else if (up_r != 4'hf) up_r <= up_r + 4'h1;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (take |=> wb_ack_out)
    else $error("no ack one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_out)
    |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_thr_fuse: assert property (up_r > 4'h6 |->
    brownout_threshold_sel_out == brownout_config_fuse_in)
    else $error("threshold differs from fuse");
  a_margin_write: assert property (wr_m |-> ##2
    monitor_margin_sel_out == $past(wb_dat_in[1:0], 2))
    else $error("margin output not written value");
  a_margin_hold: assert property (!$stable(monitor_margin_sel_out)
    |-> $past(wr_m, 2))
    else $error("margin changed without write");
  a_active_off: assert property (
    $past(detector_mode_in) == SLM_DET_DISABLED |-> !monitor_active_out)
    else $error("monitor active while detector off");
  a_irq_fall: assert property ($fell(irq_out)
    |-> $past(wb_we_in, 2) && $past(wb_cyc_in, 2))
    else $error("irq dropped without write");
endmodule

`default_nettype wire

// file: tb/slm_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module slm_regs_test;
  import slm_pkg::*;
  logic                 mclk_in, reset_in, tick, cmp, ack, act, irq;
  logic [1:0]           mode, mar;
  logic [2:0]           fuse, thr;
  logic [7:0]           lf;
  logic [SLM_DAT_W-1:0] rdat;
  slm_wb_req_s          req;
  int                   n_mismatch, n_checks, eflag, ebelow, eedge, een, emar;

  slm_regs DUT (.mclk_in(mclk_in), .reset_in(reset_in),
    .wb_cyc_in(req.cyc), .wb_stb_in(req.stb), .wb_we_in(req.we),
    .wb_sel_in(req.sel), .wb_adr_in(req.adr), .wb_dat_in(req.dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .detector_mode_in(mode),
    .detector_sample_tick_in(tick), .comparator_below_in(cmp),
    .brownout_config_fuse_in(fuse), .brownout_threshold_sel_out(thr),
    .monitor_margin_sel_out(mar), .monitor_active_out(act), .irq_out(irq));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) tick <= ~tick;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [3:0] idx,
                      input logic [7:0] d, output logic [31:0] q);
    int i;
    @(posedge mclk_in);
    req <= {1'b1, 1'b1, we, 4'h1, idx, 2'b00, 24'h0, d};
    i = 0;
    do begin
      @(posedge mclk_in);
      i++;
    end while (ack !== 1'b1 && i < 50);
    chk(ack, 1'b1);
    q = rdat;
    req <= '0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
    if (idx == SLM_IDX_MARGIN_CTRL) emar = d[1:0];
    if (idx == SLM_IDX_IRQ_FLAGS && d[0]) eflag = 0;
    if (idx == SLM_IDX_IRQ_CTRL) begin
      if (d[0] && !een && d[2:1] == 2'h2 && mode != 0 && emar != 0) eflag = 1;
      een = d[0];
      eedge = d[2:1];
    end
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(q, e);
  endtask
  // level change; the model sees a crossing only while active
  task automatic lvl(input logic b, input int n);
    @(posedge mclk_in);
    cmp <= b;
    if (mode != 0 && emar != 0 && b != ebelow) begin
      if (eedge == 2 || eedge == int'(!b)) eflag = 1;
      ebelow = b;
    end
    repeat (n) @(posedge mclk_in);
  endtask
  // first sample after activation only takes the reference
  task automatic set_mode(input logic [1:0] m);
    @(posedge mclk_in);
    mode <= m;
    repeat (6) @(posedge mclk_in);
    if (m != 0 && emar != 0) ebelow = cmp;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    end_sim;
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    lf = 8'h19;
    req = '0;
    mode = 2'h0;
    tick = 1'b0;
    cmp = 1'b0;
    reset_in = 1'b1;
    fuse = lf[2:0];
    n_mismatch = 0;
    n_checks = 0;
    eflag = 0;
    ebelow = 0;
    eedge = 0;
    een = 0;
    emar = 0;
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    rd(SLM_IDX_THRESHOLD, fuse);
    chk(thr, fuse);
    for (int i = 8; i < 12; i++) rd(4'(i), 0);
    wr(4'h3, 8'hff);
    rd(4'h3, 0);
    set_mode(SLM_DET_CONTINUOUS);
    for (int c = 0; c < 4; c++) begin
      wr(SLM_IDX_MARGIN_CTRL, 8'(c));
      rd(SLM_IDX_MARGIN_CTRL, c);
      chk(mar, c);
      chk(act, c != 0);
    end
    set_mode(SLM_DET_CONT_WAKE);
    for (int e = 0; e < 4; e++) begin
      wr(SLM_IDX_IRQ_CTRL, 8'(e << 1));
      for (int k = 0; k < 4; k++) begin
        lf = lfsr(lf);
        lvl(lf[0], 8);
        rd(SLM_IDX_LEVEL_STAT, ebelow);
        rd(SLM_IDX_IRQ_FLAGS, eflag);
        chk(irq, 1'b0);
        wr(SLM_IDX_IRQ_FLAGS, 8'h01);
      end
    end
    wr(SLM_IDX_IRQ_CTRL, 8'h05);
    rd(SLM_IDX_IRQ_FLAGS, eflag);
    rd(SLM_IDX_IRQ_CTRL, 8'h05);
    chk(irq, eflag != 0);
    wr(SLM_IDX_IRQ_FLAGS, 8'h00);
    rd(SLM_IDX_IRQ_FLAGS, eflag);
    wr(SLM_IDX_IRQ_FLAGS, 8'h01);
    rd(SLM_IDX_IRQ_FLAGS, 0);
    chk(irq, 1'b0);
    set_mode(SLM_DET_DISABLED);
    lvl(~cmp, 8);
    rd(SLM_IDX_IRQ_FLAGS, eflag);
    chk(act, 1'b0);
    set_mode(SLM_DET_SAMPLED);
    lvl(~cmp, 20);
    rd(SLM_IDX_IRQ_FLAGS, eflag);
    chk(irq, eflag != 0);
    @(posedge mclk_in);
    lf = lfsr(lf);
    {reset_in, fuse} <= {1'b1, lf[2:0]};
    // long enough that outputs fall while reset still masks the checker
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    eflag = 0;
    ebelow = 0;
    eedge = 0;
    een = 0;
    emar = 0;
    repeat (8) @(posedge mclk_in);
    rd(SLM_IDX_THRESHOLD, fuse);
    chk(thr, fuse);
    rd(SLM_IDX_IRQ_FLAGS, 0);
    end_sim;
  end
endmodule

bind slm_regs slm_regs_monitor u_mon (.mclk_in(mclk_in),
  .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .detector_mode_in(detector_mode_in),
  .brownout_config_fuse_in(brownout_config_fuse_in),
  .brownout_threshold_sel_out(brownout_threshold_sel_out),
  .monitor_margin_sel_out(monitor_margin_sel_out),
  .monitor_active_out(monitor_active_out), .irq_out(irq_out));

`default_nettype wire
